// >>> pkg/core_pc_pkg.sv
// Constants, encodings and carriers for the program counter and data addressing core.
// Assumes a single system clock and an APB master with 32-bit data.
package core_pc_pkg;
   localparam int PC_WIDTH    = 15;
   localparam int LATCH_WIDTH = 7;
   localparam int STACK_LEVELS = 16;
   localparam int DEPTH_WIDTH = 5;
   localparam int ADDR_WIDTH  = 16;
   localparam int APB_AW      = 12;
   localparam int IRQ_WIDTH   = 3;

   localparam logic [14:0] PC_RESET    = 15'h0000;
   localparam logic [14:0] PC_STEP     = 15'h0001;
   localparam logic [6:0]  LATCH_RESET = 7'h00;
   localparam logic [7:0]  BYTE_RESET  = 8'h00;
   localparam logic [4:0]  DEPTH_EMPTY = 5'h00;
   localparam logic [4:0]  DEPTH_FULL  = 5'h10;
   localparam logic [4:0]  DEPTH_STEP  = 5'h01;
   localparam logic        STACK_RESET_DEFAULT = 1'b1;

   localparam logic [6:0]  WINDOW_LAST  = 7'h01;
   localparam logic [6:0]  CORE_LAST    = 7'h0B;
   localparam logic [6:0]  SFR_LAST     = 7'h1F;
   localparam logic [6:0]  GPR_LAST     = 7'h6F;
   localparam logic [3:0]  BANK_PAD     = 4'h0;
   localparam logic [8:0]  COMMON_BASE  = 9'h000;
   localparam logic [2:0]  LINEAR_TAG   = 3'h1;

   localparam int FLAG_OVF_BIT = 7;
   localparam int FLAG_UNF_BIT = 6;
   localparam int IRQ_OVF_BIT  = 0;
   localparam int IRQ_UNF_BIT  = 1;
   localparam int IRQ_WIN_BIT  = 2;

   localparam logic [11:0] ADDR_PC_LOW     = 12'h000;
   localparam logic [11:0] ADDR_PC_LATCH   = 12'h004;
   localparam logic [11:0] ADDR_FSR0_LOW   = 12'h008;
   localparam logic [11:0] ADDR_FSR0_HIGH  = 12'h00C;
   localparam logic [11:0] ADDR_FSR1_LOW   = 12'h010;
   localparam logic [11:0] ADDR_FSR1_HIGH  = 12'h014;
   localparam logic [11:0] ADDR_RESET_CAUSE = 12'h018;
   localparam logic [11:0] ADDR_CONFIG     = 12'h01C;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h020;
   localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h024;
   localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h028;
   localparam logic [11:0] ADDR_PC_FULL    = 12'h02C;

   typedef enum logic [9:0] {
      OP_STEP      = 10'h001,
      OP_WRITE_PCL = 10'h002,
      OP_ADD_PCL   = 10'h004,
      OP_JUMP      = 10'h008,
      OP_CALL      = 10'h010,
      OP_CALL_VIA_WORKING     = 10'h020,
      OP_BRW       = 10'h040,
      OP_BRA       = 10'h080,
      OP_RETURN    = 10'h100,
      OP_HOLD      = 10'h200
   } pc_op_type;

   typedef enum logic [5:0] {
      REGION_CORE    = 6'h01,
      REGION_SFR     = 6'h02,
      REGION_GPR     = 6'h04,
      REGION_COMMON  = 6'h08,
      REGION_LINEAR  = 6'h10,
      REGION_PROGRAM = 6'h20
   } data_region_type;

   typedef struct packed {
      logic        valid;
      pc_op_type   op;
      logic [14:0] operand;
      logic [7:0]  working;
   } instr_type;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [4:0] bank;
      logic [6:0] offset;
      logic [7:0] wdata;
   } data_req_type;

   typedef struct packed {
      logic            valid;
      logic            write;
      logic [15:0]     addr;
      logic [7:0]      wdata;
      data_region_type region;
   } mem_req_type;
endpackage

// >>> design/core_pc_addressing.sv
// Program counter, return stack, file select pointers and data address decode.
// Assumes the sequencer presents one instruction per enabled cycle and memory answers
// a read combinationally in the same cycle that memReq presents it.
// Notes on behaviour
// - Fifteen-bit program counter; its low byte is readable and writable.
// - Upper seven counter bits come only from the high latch on a low-byte load.
// - Every reset source clears the whole program counter.
// - Writing the low byte loads upper bits from the latch simultaneously.
// - Absolute call takes eleven operand bits and latch bits six to three.
// - Call via working loads low byte from working, high from latch.
// - Branch by working: next counter plus working, unsigned.
// - Relative branch: next counter plus signed operand.
// - Branch arithmetic carries across the full counter width.
// - With enable set, stack overflow or underflow resets and sets a flag.
// - Window access is redirected to the pointer's address; no storage.
// - Pointer aimed at a window reads zero and suppresses the write.
// - Each pointer is a 16-bit address from high and low bytes.
// - Bank offsets 0Ch to 1Fh decode as special function area.
// - Offsets above that up to 6Fh decode as general ram.
// - Sixteen common locations map to one storage for every bank.
`timescale 1ns/10ps
`default_nettype none
module core_pc_addressing
   import core_pc_pkg::*;
(
   input  wire logic               clock,
   input  wire logic               rst_n,
   input  wire logic               clockEnable,
   input  wire logic [APB_AW-1:0]  paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire instr_type          instr,
   output logic [PC_WIDTH-1:0]     pc,
   output logic                    stackFaultReset,
   input  wire data_req_type       dataReq,
   output mem_req_type             memReq,
   input  wire logic [7:0]         memRdata,
   output logic [7:0]              dataRdata,
   output logic                    dataRdataValid,
   output logic                    irq
);

   logic [LATCH_WIDTH-1:0] pcHighLatch;
   logic [7:0]             fsrLow [2];
   logic [7:0]             fsrHigh [2];
   logic [PC_WIDTH-1:0]    stackMem [STACK_LEVELS];
   logic [DEPTH_WIDTH-1:0] depth;
   logic                   stackResetEnable;
   logic                   overflowFlag;
   logic                   underflowFlag;
   logic [IRQ_WIDTH-1:0]   irqStatus;
   logic [IRQ_WIDTH-1:0]   irqEnable;
   logic                   readPend;
   logic                   suppressPend;

   logic [PC_WIDTH-1:0]    incPc;
   logic [PC_WIDTH-1:0]    topOfStack;
   logic [DEPTH_WIDTH-1:0] depthBelow;
   logic [PC_WIDTH-1:0]    next_pc;
   logic                   push;
   logic                   pop;
   logic                   overflow;
   logic                   underflow;
   logic                   fault;
   logic                   apbAccess;
   logic                   apbWrite;
   logic                   mapped;
   logic [31:0]            readMux;
   logic                   indirect;
   logic [ADDR_WIDTH-1:0]  effAddr;
   logic [ADDR_WIDTH-1:0]  memAddr;
   data_region_type        region;
   logic                   selfHit;
   logic [IRQ_WIDTH-1:0]   events;

   function automatic data_region_type decodeRegion(input logic [ADDR_WIDTH-1:0] a);
      data_region_type r;
      r = REGION_CORE;
      if (a[15]) begin
         r = REGION_PROGRAM;
      end else if (a[15:13] == LINEAR_TAG) begin
         r = REGION_LINEAR;
      end else if (a[6:0] > CORE_LAST && a[6:0] <= SFR_LAST) begin
         r = REGION_SFR;
      end else if (a[6:0] > SFR_LAST && a[6:0] <= GPR_LAST) begin
         r = REGION_GPR;
      end else if (a[6:0] > GPR_LAST) begin
         r = REGION_COMMON;
      end
      return r;
   endfunction

   assign apbAccess = psel & penable;
   assign apbWrite  = apbAccess & pwrite & mapped;
   assign pready    = 1'b1;
   assign pslverr   = apbAccess & ~mapped;

   assign incPc      = pc + PC_STEP;
   assign depthBelow = depth - DEPTH_STEP;
   assign topOfStack = (depth == DEPTH_EMPTY) ? PC_RESET : stackMem[depthBelow[3:0]];
   assign overflow   = push & (depth == DEPTH_FULL);
   assign underflow  = pop & (depth == DEPTH_EMPTY);
   assign fault      = stackResetEnable & (overflow | underflow);

   always_comb begin
      next_pc = pc;
      push = 1'b0;
      pop = 1'b0;
      if (instr.valid) begin
         unique case (instr.op)
            OP_STEP: begin
               next_pc = incPc;
            end
            OP_WRITE_PCL: begin
               next_pc = {pcHighLatch, instr.operand[7:0]};
            end
            OP_ADD_PCL: begin
               next_pc = {pcHighLatch, incPc[7:0] + instr.working};
            end
            OP_JUMP: begin
               next_pc = {pcHighLatch[6:3], instr.operand[10:0]};
            end
            OP_CALL: begin
               next_pc = {pcHighLatch[6:3], instr.operand[10:0]};
               push = 1'b1;
            end
            OP_CALL_VIA_WORKING: begin
               next_pc = {pcHighLatch, instr.working};
               push = 1'b1;
            end
            OP_BRW: begin
               next_pc = incPc + {7'h00, instr.working};
            end
            OP_BRA: begin
               next_pc = incPc + {{6{instr.operand[8]}}, instr.operand[8:0]};
            end
            OP_RETURN: begin
               next_pc = topOfStack;
               pop = 1'b1;
            end
            OP_HOLD: begin
               next_pc = pc;
            end
            default: begin
               next_pc = pc;
            end
         endcase
      end else if (apbWrite && paddr == ADDR_PC_LOW) begin
         next_pc = {pcHighLatch, pwdata[7:0]};
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pc <= PC_RESET;
      end else if (clockEnable) begin
         if (fault) begin
            pc <= PC_RESET;
         end else begin
            pc <= next_pc;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         depth <= DEPTH_EMPTY;
      end else if (clockEnable) begin
         if (fault) begin
            depth <= DEPTH_EMPTY;
         end else if (push && !overflow) begin
            stackMem[depth[3:0]] <= incPc;
            depth <= depth + DEPTH_STEP;
         end else if (pop && !underflow) begin
            depth <= depthBelow;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stackFaultReset <= 1'b0;
      end else if (clockEnable) begin
         stackFaultReset <= fault;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n || (clockEnable && fault)) begin
         pcHighLatch <= LATCH_RESET;
         fsrLow[0] <= BYTE_RESET;
         fsrLow[1] <= BYTE_RESET;
         fsrHigh[0] <= BYTE_RESET;
         fsrHigh[1] <= BYTE_RESET;
      end else if (clockEnable && apbWrite) begin
         unique case (paddr)
            ADDR_PC_LATCH: pcHighLatch <= pwdata[6:0];
            ADDR_FSR0_LOW: fsrLow[0] <= pwdata[7:0];
            ADDR_FSR0_HIGH: fsrHigh[0] <= pwdata[7:0];
            ADDR_FSR1_LOW: fsrLow[1] <= pwdata[7:0];
            ADDR_FSR1_HIGH: fsrHigh[1] <= pwdata[7:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         overflowFlag <= 1'b0;
         underflowFlag <= 1'b0;
         stackResetEnable <= STACK_RESET_DEFAULT;
      end else if (clockEnable) begin
         if (apbWrite && paddr == ADDR_RESET_CAUSE) begin
            overflowFlag <= pwdata[FLAG_OVF_BIT] | (fault & overflow);
            underflowFlag <= pwdata[FLAG_UNF_BIT] | (fault & underflow);
         end else begin
            overflowFlag <= overflowFlag | (fault & overflow);
            underflowFlag <= underflowFlag | (fault & underflow);
         end
         if (apbWrite && paddr == ADDR_CONFIG) begin
            stackResetEnable <= pwdata[0];
         end
      end
   end

   always_comb begin
      events = '0;
      events[IRQ_OVF_BIT] = overflow;
      events[IRQ_UNF_BIT] = underflow;
      events[IRQ_WIN_BIT] = dataReq.valid & selfHit;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irqStatus <= '0;
         irqEnable <= '0;
      end else if (clockEnable) begin
         if (apbWrite && paddr == ADDR_IRQ_CLEAR) begin
            irqStatus <= (irqStatus & ~pwdata[IRQ_WIDTH-1:0]) | events;
         end else begin
            irqStatus <= irqStatus | events;
         end
         if (apbWrite && paddr == ADDR_IRQ_ENABLE) begin
            irqEnable <= pwdata[IRQ_WIDTH-1:0];
         end
      end
   end

   assign irq = |(irqStatus & irqEnable);

   always_comb begin
      readMux = 32'h0000_0000;
      mapped = 1'b1;
      unique case (paddr)
         ADDR_PC_LOW: readMux[7:0] = pc[7:0];
         ADDR_PC_LATCH: readMux[6:0] = pcHighLatch;
         ADDR_FSR0_LOW: readMux[7:0] = fsrLow[0];
         ADDR_FSR0_HIGH: readMux[7:0] = fsrHigh[0];
         ADDR_FSR1_LOW: readMux[7:0] = fsrLow[1];
         ADDR_FSR1_HIGH: readMux[7:0] = fsrHigh[1];
         ADDR_RESET_CAUSE: begin
            readMux[FLAG_OVF_BIT] = overflowFlag;
            readMux[FLAG_UNF_BIT] = underflowFlag;
         end
         ADDR_CONFIG: readMux[0] = stackResetEnable;
         ADDR_IRQ_STATUS: readMux[IRQ_WIDTH-1:0] = irqStatus;
         ADDR_IRQ_ENABLE: readMux[IRQ_WIDTH-1:0] = irqEnable;
         ADDR_IRQ_CLEAR: readMux = 32'h0000_0000;
         ADDR_PC_FULL: begin
            readMux[PC_WIDTH-1:0] = pc;
            readMux[20:16] = depth;
         end
         default: mapped = 1'b0;
      endcase
   end

   // Read data is captured in the setup phase so the access phase needs no wait.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (clockEnable && psel && !penable) begin
         prdata <= readMux;
      end
   end

   always_comb begin
      indirect = dataReq.offset <= WINDOW_LAST;
      if (indirect) begin
         effAddr = {fsrHigh[dataReq.offset[0]], fsrLow[dataReq.offset[0]]};
      end else begin
         effAddr = {BANK_PAD, dataReq.bank, dataReq.offset};
      end
      region = decodeRegion(effAddr);
      selfHit = indirect && !effAddr[15] && (effAddr[15:13] != LINEAR_TAG)
                && (effAddr[6:0] <= WINDOW_LAST);
      if (region == REGION_COMMON) begin
         memAddr = {COMMON_BASE, effAddr[6:0]};
      end else begin
         memAddr = effAddr;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         memReq <= '{valid: 1'b0, write: 1'b0, addr: '0, wdata: BYTE_RESET,
                     region: REGION_CORE};
         readPend <= 1'b0;
         suppressPend <= 1'b0;
      end else if (clockEnable) begin
         memReq.valid <= dataReq.valid & ~selfHit;
         memReq.write <= dataReq.write;
         memReq.addr <= memAddr;
         memReq.wdata <= dataReq.wdata;
         memReq.region <= region;
         readPend <= dataReq.valid & ~dataReq.write;
         suppressPend <= selfHit;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dataRdata <= BYTE_RESET;
         dataRdataValid <= 1'b0;
      end else if (clockEnable) begin
         dataRdataValid <= readPend;
         if (readPend) begin
            dataRdata <= suppressPend ? BYTE_RESET : memRdata;
         end
      end
   end

endmodule
`default_nettype wire

// >>> tb/core_pc_properties.sv
// Port checker for the program counter and data addressing core.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module core_pc_properties
   import core_pc_pkg::*;
(
   input wire logic                clock,
   input wire logic                rst_n,
   input wire logic                clockEnable,
   input wire logic [APB_AW-1:0]   paddr,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [31:0]         pwdata,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire instr_type           instr,
   input wire logic [PC_WIDTH-1:0] pc,
   input wire logic                stackFaultReset,
   input wire data_req_type        dataReq,
   input wire mem_req_type         memReq,
   input wire logic [7:0]          memRdata,
   input wire logic [7:0]          dataRdata,
   input wire logic                dataRdataValid,
   input wire logic                irq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   logic take;
   assign take = clockEnable && instr.valid;
   a_reset_clears: assert property (disable iff (1'b0) !rst_n |=>
      pc == PC_RESET && !stackFaultReset && !irq) else $error("reset left state set");
   a_step_increments: assert property (take && instr.op == OP_STEP |=>
      pc == $past(pc) + PC_STEP) else $error("pc did not step");
   a_pcl_low_load: assert property (take && instr.op == OP_WRITE_PCL |=>
      pc[7:0] == $past(instr.operand[7:0])) else $error("low byte not loaded");
   a_call_target: assert property (take && instr.op == OP_CALL |=>
      stackFaultReset || pc[10:0] == $past(instr.operand[10:0])) else $error("call target");
   a_brw_target: assert property (take && instr.op == OP_BRW |=>
      pc == $past(pc) + PC_STEP + {7'h00, $past(instr.working)}) else $error("brw target");
   a_bra_target: assert property (take && instr.op == OP_BRA |=>
      pc == $past(pc) + PC_STEP + {{6{$past(instr.operand[8])}}, $past(instr.operand[8:0])})
      else $error("bra target");
   a_fault_clears_pc: assert property (stackFaultReset |->
      pc == PC_RESET && $past(take)) else $error("fault reset without clear");
   a_sfr_decode: assert property (clockEnable && dataReq.valid
      && dataReq.offset inside {[7'h0C:7'h1F]} |=> memReq.valid
      && memReq.region == REGION_SFR && memReq.addr[6:0] == $past(dataReq.offset))
      else $error("sfr decode wrong");
   a_read_answer: assert property (clockEnable && memReq.valid && !memReq.write |=>
      dataRdataValid && dataRdata == $past(memRdata)) else $error("read result wrong");
   c_overflow: cover property (stackFaultReset);
   c_branch: cover property (take && instr.op == OP_BRA);
   c_read: cover property (dataRdataValid);
endmodule
bind core_pc_addressing core_pc_properties chk_u (.clock, .rst_n, .clockEnable, .paddr,
   .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .instr, .pc,
   .stackFaultReset, .dataReq, .memReq, .memRdata, .dataRdata, .dataRdataValid, .irq);
`default_nettype wire

// >>> tb/core_mem_model.sv
// Behavioural data memory that answers the core's memory requests.
// Assumes reads are answered in the cycle the request is shown.
`timescale 1ns/10ps
`default_nettype none
module core_mem_model
   import core_pc_pkg::*;
(
   input  wire logic        clock,
   input  wire mem_req_type memReq,
   output logic [7:0]       memRdata
);
   logic [7:0] mem [256];
   logic [7:0] last = 8'h00;
   initial begin
      foreach (mem[i]) mem[i] = 8'(i);
   end
   always @(posedge clock) begin
      if (memReq.valid && memReq.write) begin
         mem[memReq.addr[7:0]] <= memReq.wdata;
      end
      last <= memRdata;
   end
   // Idle cycles show the inverse of the previous cycle's value, so it changes every cycle.
   assign memRdata = (memReq.valid && !memReq.write) ? mem[memReq.addr[7:0]] : ~last;
endmodule
`default_nettype wire

// >>> tb/core_pc_and_data_addressing_tb.sv
// Self-checking bench for the program counter and data addressing core.
// Assumes the memory model answers reads in the request cycle.
`timescale 1ns/10ps
`default_nettype none
module core_pc_and_data_addressing_tb
   import core_pc_pkg::*;
;
   typedef struct packed {
      pc_op_type   op;
      logic [14:0] arg;
      logic [7:0]  w;
      logic [14:0] pcx;
   } row_type;
   logic           clock = 1'b0;
   logic           rst_n = 1'b0;
   logic           clockEnable = 1'b1;
   logic [11:0]    paddr = 12'h000;
   logic           psel = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite = 1'b0;
   logic [31:0]    pwdata = 32'h00000000;
   logic [31:0]    prdata;
   logic           pready;
   logic           pslverr;
   instr_type      instr = '0;
   logic [14:0]    pc;
   logic           stackFaultReset;
   data_req_type   dataReq = '0;
   mem_req_type    memReq;
   logic [7:0]     memRdata;
   logic [7:0]     dataRdata;
   logic           dataRdataValid;
   logic           irq;
   logic [31:0]    q;
   logic           e;
   int             mismatches = 0;
   int             totalChecks = 0;
   row_type rows [14] = '{
      '{OP_STEP, 15'h0000, 8'h00, 15'h0001}, '{OP_WRITE_PCL, 15'h0034, 8'h00, 15'h5A34},
      '{OP_STEP, 15'h0000, 8'h00, 15'h5A35}, '{OP_BRA, 15'h01F0, 8'h00, 15'h5A26},
      '{OP_BRW, 15'h0000, 8'hFF, 15'h5B26}, '{OP_BRA, 15'h00FF, 8'h00, 15'h5C26},
      '{OP_BRA, 15'h0100, 8'h00, 15'h5B27}, '{OP_ADD_PCL, 15'h0000, 8'hF0, 15'h5A18},
      '{OP_JUMP, 15'h7ABC, 8'h00, 15'h5ABC}, '{OP_CALL, 15'h0123, 8'h00, 15'h5923},
      '{OP_CALL_VIA_WORKING, 15'h0000, 8'h77, 15'h5A77}, '{OP_RETURN, 15'h0000, 8'h00, 15'h5924},
      '{OP_RETURN, 15'h0000, 8'h00, 15'h5ABD}, '{OP_HOLD, 15'h0000, 8'h00, 15'h5ABD}};
   always #10 clock = ~clock;
   core_pc_addressing dut_u (.clock, .rst_n, .clockEnable, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .instr, .pc, .stackFaultReset,
      .dataReq, .memReq, .memRdata, .dataRdata, .dataRdataValid, .irq);
   core_mem_model partner_u (.clock, .memReq, .memRdata);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic testEnd(input string s);
      $display("test %s done", s);
   endtask
   task automatic testDone;
      $display("checks=%0d mismatches=%0d", totalChecks, mismatches);
      if (mismatches == 0 && totalChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic ex(input pc_op_type op, input logic [14:0] a, input logic [7:0] w);
      @(posedge clock);
      instr <= '{1'b1, op, a, w};
      @(posedge clock);
      instr.valid <= 1'b0;
      #1;
   endtask
   task automatic dx(input logic w, input logic [4:0] b, input logic [6:0] o,
         input logic [15:0] ea, input data_region_type er, input logic ev, input logic [7:0] ed);
      @(posedge clock);
      dataReq <= '{1'b1, w, b, o, ed};
      @(posedge clock);
      dataReq.valid <= 1'b0;
      #1;
      chk(memReq.valid, ev);
      if (ev) begin
         chk(memReq.addr, ea);
         chk(memReq.region, er);
      end
      if (!w) begin
         @(posedge clock);
         #1;
         chk(dataRdataValid, 1'b1);
         chk(dataRdata, ed);
      end
   endtask
   initial begin
      repeat (5000) @(posedge clock);
      mismatches++;
      testDone;
   end
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      chk(pc, 15'h0000);
      apb(ADDR_CONFIG, 1'b0, 32'h0);
      chk(q, 32'h1);
      apb(ADDR_PC_LATCH, 1'b1, 32'h5A);
      // Computed jump row wraps its low byte without carry and takes upper bits from the latch.
      foreach (rows[i]) begin
         ex(rows[i].op, rows[i].arg, rows[i].w);
         chk(pc, rows[i].pcx);
      end
      @(posedge clock);
      clockEnable <= 1'b0;
      ex(OP_STEP, 15'h0, 8'h0);
      chk(pc, 15'h5ABD);
      clockEnable <= 1'b1;
      apb(ADDR_PC_FULL, 1'b0, 32'h0);
      chk(q, 32'h5ABD);
      apb(ADDR_PC_LOW, 1'b0, 32'h0);
      chk(q, 32'hBD);
      apb(ADDR_PC_LOW, 1'b1, 32'h11);
      #1;
      chk(pc, 15'h5A11);
      testEnd("pc");
      repeat (17) ex(OP_CALL, 15'h0040, 8'h0);
      chk(stackFaultReset, 1'b1);
      chk(pc, 15'h0000);
      apb(ADDR_RESET_CAUSE, 1'b0, 32'h0);
      chk(q[7:6], 2'b10);
      chk(irq, 1'b0);
      apb(ADDR_IRQ_ENABLE, 1'b1, 32'h7);
      #1;
      chk(irq, 1'b1);
      apb(ADDR_IRQ_CLEAR, 1'b1, 32'h7);
      #1;
      chk(irq, 1'b0);
      apb(ADDR_RESET_CAUSE, 1'b1, 32'h0);
      ex(OP_RETURN, 15'h0, 8'h0);
      chk(stackFaultReset, 1'b1);
      apb(ADDR_RESET_CAUSE, 1'b0, 32'h0);
      chk(q[7:6], 2'b01);
      apb(ADDR_IRQ_CLEAR, 1'b1, 32'h7);
      apb(ADDR_CONFIG, 1'b1, 32'h0);
      repeat (17) ex(OP_CALL, 15'h0040, 8'h0);
      chk(stackFaultReset, 1'b0);
      chk(pc, 15'h0040);
      testEnd("stack");
      apb(12'h0FC, 1'b0, 32'h0);
      chk(e, 1'b1);
      chk(q, 32'h0);
      dx(1'b1, 5'h02, 7'h30, 16'h0130, REGION_GPR, 1'b1, 8'hA5);
      dx(1'b0, 5'h02, 7'h30, 16'h0130, REGION_GPR, 1'b1, 8'hA5);
      dx(1'b0, 5'h03, 7'h10, 16'h0190, REGION_SFR, 1'b1, 8'h90);
      dx(1'b0, 5'h01, 7'h05, 16'h0085, REGION_CORE, 1'b1, 8'h85);
      dx(1'b0, 5'h05, 7'h75, 16'h0075, REGION_COMMON, 1'b1, 8'h75);
      apb(ADDR_FSR0_LOW, 1'b1, 32'h45);
      apb(ADDR_FSR0_HIGH, 1'b1, 32'h23);
      dx(1'b0, 5'h00, 7'h00, 16'h2345, REGION_LINEAR, 1'b1, 8'h45);
      apb(ADDR_FSR1_LOW, 1'b1, 32'h01);
      apb(ADDR_FSR1_HIGH, 1'b1, 32'h00);
      dx(1'b1, 5'h00, 7'h01, 16'h0, REGION_CORE, 1'b0, 8'h33);
      dx(1'b0, 5'h00, 7'h01, 16'h0, REGION_CORE, 1'b0, 8'h00);
      apb(ADDR_IRQ_STATUS, 1'b0, 32'h0);
      chk(q[2], 1'b1);
      testEnd("data");
      @(posedge clock);
      rst_n <= 1'b0;
      @(posedge clock);
      rst_n <= 1'b1;
      #1;
      chk(pc, 15'h0000);
      chk(irq, 1'b0);
      testEnd("reset");
      testDone;
   end
endmodule
`default_nettype wire
